// file: common/xcvr_cfg_pkg.sv
// Package with register map, field layout and decoded types of the config bank.
package xcvr_cfg_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_GCON = 8'h00;
  localparam logic [7:0] ADDR_RSSI = 8'h14;
  localparam logic [7:0] ADDR_OOK = 8'h15;
  localparam logic [7:0] ADDR_SYNC1 = 8'h16;
  localparam logic [7:0] ADDR_SYNC2 = 8'h17;
  localparam logic [7:0] ADDR_SYNC3 = 8'h18;
  localparam logic [7:0] ADDR_SYNC4 = 8'h19;
  localparam logic [7:0] ADDR_TXCON = 8'h1a;
  localparam logic [7:0] ADDR_CLKO = 8'h1b;
  localparam logic [7:0] ADDR_PLOAD = 8'h1c;
  localparam logic [7:0] ADDR_NODE = 8'h1d;
  localparam logic [7:0] ADDR_PKTC = 8'h1e;
  localparam logic [7:0] ADDR_FCRC = 8'h1f;
  // Byte bank 0x15..0x1f is one indexed array.
  localparam int BANK_COUNT = 11;
  localparam logic [3:0] IDX_OOK = 4'h0;
  localparam logic [3:0] IDX_SYNC1 = 4'h1;
  localparam logic [3:0] IDX_SYNC2 = 4'h2;
  localparam logic [3:0] IDX_SYNC3 = 4'h3;
  localparam logic [3:0] IDX_SYNC4 = 4'h4;
  localparam logic [3:0] IDX_TXCON = 4'h5;
  localparam logic [3:0] IDX_CLKO = 4'h6;
  localparam logic [3:0] IDX_PLOAD = 4'h7;
  localparam logic [3:0] IDX_NODE = 4'h8;
  localparam logic [3:0] IDX_PKTC = 4'h9;
  localparam logic [3:0] IDX_FCRC = 4'ha;
  // Reset values.
  localparam logic [7:0] GCON_RESET = 8'h28;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // General configuration field positions.
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int BAND_HI = 4;
  localparam int BAND_LO = 3;
  localparam int VCO_HI = 2;
  localparam int VCO_LO = 1;
  localparam int DIV_BIT = 0;
  // Operating mode codes.
  localparam logic [2:0] CODE_SLEEP = 3'h0;
  localparam logic [2:0] CODE_STANDBY = 3'h1;
  localparam logic [2:0] CODE_SYNTH = 3'h2;
  localparam logic [2:0] CODE_RX = 3'h3;
  localparam logic [2:0] CODE_TX = 3'h4;
  // Band codes.
  localparam logic [1:0] CODE_BAND_LOW = 2'h0;
  localparam logic [1:0] CODE_BAND_MID = 2'h1;
  localparam logic [1:0] CODE_BAND_ALT = 2'h2;
  // Tuning offset per code step, in millivolts.
  localparam logic [7:0] VCO_STEP_MV = 8'h3c;
  // Bits of the packet and fifo registers.
  localparam int PKT_CRC_STAT_BIT = 0;
  localparam int PKT_ADDR_FILT_BIT = 2;
  localparam int FCRC_AUTOCLR_BIT = 7;

  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_RECEIVE, MODE_TRANSMIT, MODE_RESERVED
  } mode_t;

  typedef enum logic [1:0] {
    BAND_902_915, BAND_915_928, BAND_ALT, BAND_RESERVED
  } band_t;

  typedef struct packed {
    mode_t mode;
    band_t band;
    logic [7:0] vco_mv;
    logic div_set_two;
  } radio_ctrl_t;
endpackage : xcvr_cfg_pkg

// file: dv/tb.sv
// Self-checking testbench for the transceiver configuration register bank.
`timescale 1ns/1ps
module tb;
  import xcvr_cfg_pkg::*;
  // Clock, reset and register port.
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  // Radio status inputs.
  logic [7:0] rssi = 8'h00;
  logic afc = 1'b0;
  logic crc_done = 1'b0;
  logic crc_ok = 1'b0;
  logic [7:0] rx_addr = 8'h00;
  logic rx_valid = 1'b0;
  // Design outputs.
  radio_ctrl_t ctrl;
  logic [31:0] sync_word;
  logic [7:0] ook_cfg, tx_cfg, clko_cfg, pload_cfg, node_addr, pkt_cfg, fifo_cfg;
  logic addr_match;
  logic fifo_clear;
  // Bookkeeping and expectation tables.
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] exp_q [$];
  logic rd_d = 1'b0;
  logic [7:0] bank_val [32];
  logic [7:0] hole [4] = '{8'h01, 8'h13, 8'h20, 8'hff};
  mode_t exp_mode [8] = '{MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_RECEIVE, MODE_TRANSMIT,
    MODE_RESERVED, MODE_RESERVED, MODE_RESERVED};
  band_t exp_band [4] = '{BAND_902_915, BAND_915_928, BAND_ALT, BAND_RESERVED};

  // The clock toggles every half period of 10 ns.
  always #10 clk = ~clk;

  transceiver_config_regs dut_u (
    .CORE_CLK_IN(clk), .RST_B_IN(rst_b),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .RSSI_IN(rssi), .AFC_RUN_IN(afc),
    .CRC_DONE_IN(crc_done), .CRC_OK_IN(crc_ok),
    .RX_ADDR_IN(rx_addr), .RX_ADDR_VALID_IN(rx_valid),
    .RADIO_CTRL_OUT(ctrl), .SYNC_WORD_OUT(sync_word), .OOK_CFG_OUT(ook_cfg),
    .TX_CFG_OUT(tx_cfg), .CLK_OUT_CFG_OUT(clko_cfg), .PAYLOAD_CFG_OUT(pload_cfg),
    .NODE_ADDR_OUT(node_addr), .PKT_CFG_OUT(pkt_cfg), .FIFO_CFG_OUT(fifo_cfg),
    .ADDR_MATCH_OUT(addr_match), .FIFO_CLEAR_OUT(fifo_clear)
  );

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // One-cycle register write, strobe left up for a back-to-back follower.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask : wr_reg

  // One-cycle register read; the expected data goes into the queue.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_q.push_back(e);
  endtask : rd_reg

  // Drops the write, read and AFC strobes and waits until decoded outputs have settled.
  task automatic settle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    afc <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Raw output byte that mirrors a bank address.
  function automatic logic [7:0] raw_out(input logic [7:0] a);
    case (a)
      8'h15: return ook_cfg;
      8'h16: return sync_word[31:24];
      8'h17: return sync_word[23:16];
      8'h18: return sync_word[15:8];
      8'h19: return sync_word[7:0];
      8'h1a: return tx_cfg;
      8'h1b: return clko_cfg;
      8'h1c: return pload_cfg;
      8'h1d: return node_addr;
      8'h1e: return pkt_cfg;
      default: return fifo_cfg;
    endcase
  endfunction : raw_out

  // Read data stands only in the cycle after a read strobe and is zero otherwise.
  // Flops hold no known value before the first reset edge, so checks start after reset.
  always @(posedge clk) begin
    if (rst_b) begin
      if (rd_d) begin
        check("read data", {24'h0, rdata}, {24'h0, exp_q.pop_front()});
      end else begin
        check("idle read data", {24'h0, rdata}, 32'h0);
      end
    end
    rd_d <= rd;
  end

  // Watchdog cuts a hang short; the tests need about two hundred cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // Main sequence.
  initial begin
    logic [7:0] v;
    logic [7:0] g;
    void'($urandom(32'h9232));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    check("mode", 32'(ctrl.mode), 32'(MODE_STANDBY));
    check("band", 32'(ctrl.band), 32'(BAND_915_928));
    check("vco", 32'(ctrl.vco_mv), 32'h0);
    check("divider", 32'(ctrl.div_set_two), 32'h0);
    rd_reg(8'h00, 8'h28);
    for (int a = 'h15; a <= 'h1f; a++) begin
      rd_reg(8'(a), 8'h00);
    end
    settle();
    // Every legal mode code and every band code decoded; reserved modes are never written.
    for (int i = 0; i < 5; i++) begin
      g = {3'(i), 2'(i), 2'($urandom), i[0]};
      wr_reg(8'h00, g);
      rd_reg(8'h00, g);
      settle();
      check("mode", 32'(ctrl.mode), 32'(exp_mode[i]));
      check("band", 32'(ctrl.band), 32'(exp_band[i[1:0]]));
      check("vco", 32'(ctrl.vco_mv), 32'(8'h3c * g[2:1]));
      check("divider", 32'(ctrl.div_set_two), 32'(g[0]));
    end
    // Tuning bits invert on each AFC run; a write in the same cycle wins.
    wr_reg(8'h00, 8'h22);
    settle();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      afc <= 1'b1;
      @(posedge clk);
      afc <= 1'b0;
      @(posedge clk);
      #1;
      check("vco", 32'(ctrl.vco_mv), (i == 0) ? 32'h78 : 32'h3c);
    end
    // Two runs back to back return the tuning bits to where they were.
    @(posedge clk);
    afc <= 1'b1;
    repeat (2) @(posedge clk);
    afc <= 1'b0;
    @(posedge clk);
    #1;
    check("vco", 32'(ctrl.vco_mv), 32'h3c);
    @(posedge clk);
    afc <= 1'b1;
    addr <= 8'h00;
    wdata <= 8'h26;
    wr <= 1'b1;
    settle();
    check("vco", 32'(ctrl.vco_mv), 32'hb4);
    // Bank filled back to back, then outputs and read-back compared.
    for (int a = 'h15; a <= 'h1f; a++) begin
      bank_val[a] = 8'($urandom);
      wr_reg(8'(a), bank_val[a]);
    end
    settle();
    for (int a = 'h15; a <= 'h1f; a++) begin
      v = (a == 'h1e) ? {bank_val[a][7:1], 1'b0} : bank_val[a];
      check("bank output", 32'(raw_out(8'(a))), 32'(bank_val[a]));
      rd_reg(8'(a), v);
    end
    settle();
    check("sync word", sync_word,
      {bank_val['h16], bank_val['h17], bank_val['h18], bank_val['h19]});
    // Writes outside the map change nothing and read as zero.
    foreach (hole[k]) begin
      wr_reg(hole[k], 8'hff);
      rd_reg(hole[k], 8'h00);
    end
    wr_reg(8'h14, 8'hff);
    rd_reg(8'h00, 8'h26);
    settle();
    check("sync word", sync_word,
      {bank_val['h16], bank_val['h17], bank_val['h18], bank_val['h19]});
    // Signal strength read returns the value present at the strobe.
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      @(posedge clk);
      rssi <= v;
      rd_reg(8'h14, v);
      settle();
    end
    // CRC result with auto-clear on and off.
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h1f, {i[1], 7'h00});
      settle();
      @(posedge clk);
      crc_done <= 1'b1;
      crc_ok <= i[0];
      // Status is read back in the cycle right after the check ends.
      rd_reg(8'h1e, {bank_val['h1e][7:1], i[0]});
      crc_done <= 1'b0;
      crc_ok <= ~i[0];
      #1;
      check("fifo clear", 32'(fifo_clear), (i[1] && !i[0]) ? 32'h1 : 32'h0);
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("fifo clear", 32'(fifo_clear), 32'h0);
      settle();
    end
    // Address compare with the filter on and off.
    wr_reg(8'h1d, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h1e, {5'h00, i[1], 2'h0});
      settle();
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_addr <= i[0] ? 8'ha5 : 8'h5a;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_addr <= 8'h00;
      #1;
      check("address match", 32'(addr_match), (i[1] && !i[0]) ? 32'h0 : 32'h1);
    end
    settle();
    complete_run();
  end
endmodule : tb

// file: hw/gcon_decoder.sv
// Decoder from the general configuration byte to radio control fields.
`timescale 1ns/1ps
module gcon_decoder
  import xcvr_cfg_pkg::*;
(
  // Raw register byte.
  input wire logic [7:0] gcon_in,
  // Decoded controls.
  output radio_ctrl_t ctrl_out
);

  // Mode, band, tuning offset and divider set decode.
  always_comb begin
    ctrl_out = '0;
    unique case (gcon_in[MODE_HI:MODE_LO]) // RL1
      CODE_SLEEP: ctrl_out.mode = MODE_SLEEP;
      CODE_STANDBY: ctrl_out.mode = MODE_STANDBY;
      CODE_SYNTH: ctrl_out.mode = MODE_SYNTH;
      CODE_RX: ctrl_out.mode = MODE_RECEIVE;
      CODE_TX: ctrl_out.mode = MODE_TRANSMIT;
      default: ctrl_out.mode = MODE_RESERVED; // RL2
    endcase
    unique case (gcon_in[BAND_HI:BAND_LO]) // RL4
      CODE_BAND_LOW: ctrl_out.band = BAND_902_915;
      CODE_BAND_MID: ctrl_out.band = BAND_915_928;
      CODE_BAND_ALT: ctrl_out.band = BAND_ALT;
      default: ctrl_out.band = BAND_RESERVED;
    endcase
    // Offset grows by one step per code value.
    ctrl_out.vco_mv = 8'(VCO_STEP_MV * gcon_in[VCO_HI:VCO_LO]); // RL5
    ctrl_out.div_set_two = gcon_in[DIV_BIT]; // RL7
  end

endmodule : gcon_decoder

// file: hw/transceiver_config_regs.sv
// Configuration register bank of the sub-GHz transceiver.
// Function
// [RL1] Decode mode: 100 tx, 011 rx, 010 synth.
// [RL2] Software never writes mode codes 101-111.
// [RL3] General configuration resets to 0x28.
// [RL4] Decode band field into three bands.
// [RL5] Tuning field gives 0/60/120/180 mV offset.
// [RL6] Tuning bits toggle on each AFC run. A write in the same cycle wins and no toggle occurs.
// [RL7] Divider select one picks second divider set.
// [RL8] Sync word built from 0x16 to 0x19.
// [RL9] Read of 0x14 returns signal strength.
// [RL10] Register 0x15 holds on-off keying settings.
// [RL11] Register 0x1A holds transmit settings.
// [RL12] Register 0x1B holds clock output control.
// [RL13] Register 0x1C holds payload settings.
// [RL14] Node address compared when filtering active.
// [RL15] Register 0x1E holds packet settings, CRC status.
// [RL16] Register 0x1F holds FIFO control, auto-clear.
// [RL17] Byte-wide registers; undefined bits change nothing.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module transceiver_config_regs
  import xcvr_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  // Register port.
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Status from the radio logic.
  input wire logic [7:0] RSSI_IN,
  input wire logic AFC_RUN_IN,
  input wire logic CRC_DONE_IN,
  input wire logic CRC_OK_IN,
  input wire logic [7:0] RX_ADDR_IN,
  input wire logic RX_ADDR_VALID_IN,
  // Controls to the radio logic.
  output radio_ctrl_t RADIO_CTRL_OUT,
  output logic [31:0] SYNC_WORD_OUT,
  output logic [7:0] OOK_CFG_OUT,
  output logic [7:0] TX_CFG_OUT,
  output logic [7:0] CLK_OUT_CFG_OUT,
  output logic [7:0] PAYLOAD_CFG_OUT,
  output logic [7:0] NODE_ADDR_OUT,
  output logic [7:0] PKT_CFG_OUT,
  output logic [7:0] FIFO_CFG_OUT,
  output logic ADDR_MATCH_OUT,
  output logic FIFO_CLEAR_OUT
);

  logic [7:0] gcon_reg;
  logic [7:0] gcon_next;
  logic [7:0] bank_reg [BANK_COUNT];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic crc_status_reg;
  logic addr_match_reg;
  logic fifo_clear_reg;
  radio_ctrl_t ctrl_dec;
  radio_ctrl_t ctrl_reg;
  logic gcon_wr;
  logic in_bank;
  logic [7:0] bank_off;
  logic [3:0] bank_idx;
  logic filt_en;
  logic autoclr_en;
  logic touched_reg;

  // Address decode of the write strobe and the byte bank.
  assign gcon_wr = REG_WR_IN && (REG_ADDR_IN == ADDR_GCON);
  assign in_bank = (REG_ADDR_IN >= ADDR_OOK) && (REG_ADDR_IN <= ADDR_FCRC);
  assign bank_off = REG_ADDR_IN - ADDR_OOK;
  assign bank_idx = bank_off[3:0];
  assign filt_en = bank_reg[IDX_PKTC][PKT_ADDR_FILT_BIT];
  assign autoclr_en = bank_reg[IDX_FCRC][FCRC_AUTOCLR_BIT];

  // Next general configuration: a write wins over an AFC toggle.
  always_comb begin
    gcon_next = gcon_reg;
    if (gcon_wr) begin
      gcon_next = REG_WDATA_IN;
    end else if (AFC_RUN_IN) begin
      gcon_next[VCO_HI:VCO_LO] = ~gcon_reg[VCO_HI:VCO_LO]; // RL6
    end
  end

  // General configuration register.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      gcon_reg <= GCON_RESET; // RL3
    end else begin
      gcon_reg <= gcon_next;
    end
  end

  // Byte bank 0x15..0x1f, one flop group per entry.
  generate
    for (genvar i = 0; i < BANK_COUNT; i++) begin : g_bank
      always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          bank_reg[i] <= BANK_RESET;
        end else if (REG_WR_IN && in_bank && (bank_idx == 4'(i))) begin
          bank_reg[i] <= REG_WDATA_IN; // RL10 RL11 RL12 RL13 RL17
        end
      end
    end
  endgenerate

  // Decoder of the general configuration byte.
  gcon_decoder u_gcon_decoder (
    .gcon_in(gcon_reg),
    .ctrl_out(ctrl_dec)
  );

  // Registered radio controls.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_dec; // RL1 RL4 RL5 RL7
    end
  end

  // Last CRC result, kept until the next check ends.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      crc_status_reg <= 1'b0;
    end else if (CRC_DONE_IN) begin
      crc_status_reg <= CRC_OK_IN; // RL15
    end
  end

  // FIFO clear pulse after a failed check when auto-clear is set.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      fifo_clear_reg <= 1'b0;
    end else begin
      fifo_clear_reg <= CRC_DONE_IN && !CRC_OK_IN && autoclr_en; // RL16
    end
  end

  // Address filter result, updated for each received address.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      addr_match_reg <= 1'b0;
    end else if (RX_ADDR_VALID_IN) begin
      addr_match_reg <= !filt_en || (RX_ADDR_IN == bank_reg[IDX_NODE]); // RL14
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rdata_next = READ_IDLE;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == ADDR_GCON) begin
        rdata_next = gcon_reg;
      end else if (REG_ADDR_IN == ADDR_RSSI) begin
        rdata_next = RSSI_IN; // RL9
      end else if (REG_ADDR_IN == ADDR_PKTC) begin
        rdata_next = bank_reg[IDX_PKTC];
        rdata_next[PKT_CRC_STAT_BIT] = crc_status_reg; // RL15
      end else if (in_bank) begin
        rdata_next = bank_reg[bank_idx];
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rdata_reg <= READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flops.
  assign REG_RDATA_OUT = rdata_reg;
  assign RADIO_CTRL_OUT = ctrl_reg;
  assign SYNC_WORD_OUT = {bank_reg[IDX_SYNC1], bank_reg[IDX_SYNC2],
                          bank_reg[IDX_SYNC3], bank_reg[IDX_SYNC4]}; // RL8
  assign OOK_CFG_OUT = bank_reg[IDX_OOK];
  assign TX_CFG_OUT = bank_reg[IDX_TXCON];
  assign CLK_OUT_CFG_OUT = bank_reg[IDX_CLKO];
  assign PAYLOAD_CFG_OUT = bank_reg[IDX_PLOAD];
  assign NODE_ADDR_OUT = bank_reg[IDX_NODE];
  assign PKT_CFG_OUT = bank_reg[IDX_PKTC];
  assign FIFO_CFG_OUT = bank_reg[IDX_FCRC];
  assign ADDR_MATCH_OUT = addr_match_reg;
  assign FIFO_CLEAR_OUT = fifo_clear_reg;

  // Marks the first change of the general configuration after reset.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      touched_reg <= 1'b0;
    end else if (gcon_wr || AFC_RUN_IN) begin
      touched_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // Mode write reaches the decoded output two edges later.
  sequence s_tx_write;
    gcon_wr && (REG_WDATA_IN[MODE_HI:MODE_LO] == CODE_TX) ##1 !gcon_wr;
  endsequence
  property p_mode_tx;
    s_tx_write |=> RADIO_CTRL_OUT.mode == MODE_TRANSMIT;
  endproperty
  a_mode_tx: assert property (p_mode_tx) // RL1
    else $error("transmit code did not give transmit mode");

  // Receive code decodes to receive mode.
  property p_mode_rx;
    gcon_reg[MODE_HI:MODE_LO] == CODE_RX |=> RADIO_CTRL_OUT.mode == MODE_RECEIVE;
  endproperty
  a_mode_rx: assert property (p_mode_rx) // RL1
    else $error("receive code did not give receive mode");

  // Untouched register holds its reset value of 0x28.
  property p_reset_value;
    !touched_reg |-> gcon_reg == GCON_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) // RL3
    else $error("general configuration left its reset value");

  // Band code 00 decodes to the low band.
  property p_band;
    gcon_reg[BAND_HI:BAND_LO] == CODE_BAND_LOW |=> RADIO_CTRL_OUT.band == BAND_902_915;
  endproperty
  a_band: assert property (p_band) // RL4
    else $error("band code 00 did not decode to the low band");

  // Tuning offset is the code times one step.
  property p_vco_mv;
    RADIO_CTRL_OUT.vco_mv == 8'(VCO_STEP_MV * $past(gcon_reg[VCO_HI:VCO_LO]));
  endproperty
  a_vco_mv: assert property (p_vco_mv) // RL5
    else $error("tuning offset does not match tuning code");

  // AFC run inverts both tuning bits and keeps the mode and band bits.
  property p_afc_toggle;
    AFC_RUN_IN && !gcon_wr |=>
      (gcon_reg[VCO_HI:VCO_LO] == ~$past(gcon_reg[VCO_HI:VCO_LO]))
      && (gcon_reg[MODE_HI:BAND_LO] == $past(gcon_reg[MODE_HI:BAND_LO]));
  endproperty
  a_afc_toggle: assert property (p_afc_toggle) // RL6
    else $error("tuning bits did not toggle on AFC run");

  // Divider set follows bit 0 one edge later.
  property p_div_set;
    RADIO_CTRL_OUT.div_set_two == $past(gcon_reg[DIV_BIT]);
  endproperty
  a_div_set: assert property (p_div_set) // RL7
    else $error("divider set does not follow select bit");

  // First sync byte lands in the top byte of the word.
  property p_sync_first;
    REG_WR_IN && (REG_ADDR_IN == ADDR_SYNC1) |=>
      SYNC_WORD_OUT[31:24] == $past(REG_WDATA_IN);
  endproperty
  a_sync_first: assert property (p_sync_first) // RL8
    else $error("first sync byte not at top of sync word");

  // Fourth sync byte lands in the bottom byte.
  property p_sync_last;
    REG_WR_IN && (REG_ADDR_IN == ADDR_SYNC4) |=>
      SYNC_WORD_OUT[7:0] == $past(REG_WDATA_IN);
  endproperty
  a_sync_last: assert property (p_sync_last) // RL8
    else $error("fourth sync byte not at bottom of sync word");

  // Signal strength read returns the value sampled at the strobe.
  property p_rssi_read;
    REG_RD_IN && (REG_ADDR_IN == ADDR_RSSI) |=> REG_RDATA_OUT == $past(RSSI_IN);
  endproperty
  a_rssi_read: assert property (p_rssi_read) // RL9
    else $error("signal strength read returned wrong data");

  // Address filter compares against the stored node address.
  property p_addr_filter;
    RX_ADDR_VALID_IN && filt_en |=>
      ADDR_MATCH_OUT == ($past(RX_ADDR_IN) == $past(bank_reg[IDX_NODE]));
  endproperty
  a_addr_filter: assert property (p_addr_filter) // RL14
    else $error("address match does not reflect node address");

  // CRC status read back after a check.
  property p_crc_status;
    CRC_DONE_IN ##1 (REG_RD_IN && (REG_ADDR_IN == ADDR_PKTC) && !CRC_DONE_IN) |=>
      REG_RDATA_OUT[PKT_CRC_STAT_BIT] == $past(CRC_OK_IN, 2);
  endproperty
  a_crc_status: assert property (p_crc_status) // RL15
    else $error("CRC status bit wrong on read");

  // FIFO clears only after a failed check with auto-clear set.
  property p_fifo_clear;
    FIFO_CLEAR_OUT |-> $past(CRC_DONE_IN && !CRC_OK_IN && autoclr_en);
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) // RL16
    else $error("FIFO clear without failed check");

  // Reads outside the map and idle cycles give zero.
  property p_unmapped_zero;
    !(REG_RD_IN && ((REG_ADDR_IN == ADDR_GCON) || (REG_ADDR_IN == ADDR_RSSI) || in_bank))
      |=> REG_RDATA_OUT == READ_IDLE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // RL17
    else $error("read data not zero outside a mapped read");

  // A failed check with auto-clear set always pulses the FIFO clear.
  property p_fifo_clear_fire;
    CRC_DONE_IN && !CRC_OK_IN && autoclr_en |=> FIFO_CLEAR_OUT;
  endproperty
  a_fifo_clear_fire: assert property (p_fifo_clear_fire) // RL16
    else $error("failed check with auto-clear gave no FIFO clear");

  // Band code 01 decodes to the upper band.
  property p_band_mid;
    gcon_reg[BAND_HI:BAND_LO] == CODE_BAND_MID |=> RADIO_CTRL_OUT.band == BAND_915_928;
  endproperty
  a_band_mid: assert property (p_band_mid) // RL4
    else $error("band code 01 did not decode to the upper band");

  // Second sync byte lands in the second byte of the word.
  property p_sync_mid;
    REG_WR_IN && (REG_ADDR_IN == ADDR_SYNC2) |=>
      SYNC_WORD_OUT[23:16] == $past(REG_WDATA_IN);
  endproperty
  a_sync_mid: assert property (p_sync_mid) // RL8
    else $error("second sync byte not in second byte of sync word");

  // CRC status only moves when a check ends.
  property p_crc_hold;
    !CRC_DONE_IN |=> $stable(crc_status_reg);
  endproperty
  a_crc_hold: assert property (p_crc_hold) // RL15
    else $error("CRC status changed without a check");

  // Main scenarios.
  c_tx_mode: cover property (s_tx_write ##1 RADIO_CTRL_OUT.mode == MODE_TRANSMIT);
  c_afc_toggle: cover property (AFC_RUN_IN ##1 AFC_RUN_IN);
  c_fifo_clear: cover property (FIFO_CLEAR_OUT);
  c_addr_hit: cover property (filt_en && ADDR_MATCH_OUT);
  c_crc_read: cover property (CRC_DONE_IN ##1 (REG_RD_IN && (REG_ADDR_IN == ADDR_PKTC)));

endmodule : transceiver_config_regs
